// ---- hw/link_status_pkg.sv ----
// constants, register map and field layout for the link status monitor
package link_status_pkg;
	localparam int NUM_LANES = 8;
	localparam logic [6:0] WORD_LOCK_GOOD = 7'h40;
	localparam logic [4:0] WORD_LOSS_BAD = 5'h10;
	localparam logic [5:0] WORD_WINDOW_LAST = 6'h3F;
	localparam logic [2:0] SYNC_LOCK_GOOD = 3'h4;
	localparam logic [2:0] SYNC_LOSS_BAD = 3'h4;
	localparam logic [28:0] LOCK_TICK_CYCLES = 29'h12F4_4B80;
	localparam logic [15:0] COUNT16_FULL = 16'hFFFF;
	localparam logic [7:0] COUNT8_FULL = 8'hFF;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_HUNGRY_THRESH = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_FLAGS = 8'h0C;
	localparam logic [7:0] REG_LOCKED_TIME = 8'h10;
	localparam logic [7:0] REG_CRC24_COUNT = 8'h14;
	localparam logic [7:0] REG_WORD_LOCK = 8'h18;
	localparam logic [7:0] REG_SYNC_LOCK = 8'h1C;
	localparam logic [7:0] REG_CRC32_LO = 8'h20;
	localparam logic [7:0] REG_CRC32_HI = 8'h24;

	localparam int CTRL_PROTECT_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam logic CTRL_PROTECT_RESET = 1'b1;
	localparam logic [7:0] HUNGRY_THRESH_RESET = 8'h04;

	localparam int STATUS_ALL_WORD_BIT = 0;
	localparam int STATUS_ALL_SYNC_BIT = 1;
	localparam int STATUS_FULL_BIT = 2;
	localparam int STATUS_ALIGN_BIT = 3;

	localparam int FLAG_RX_OVERFLOW = 0;
	localparam int FLAG_TX_OVERFLOW = 1;
	localparam int FLAG_TX_UNDERFLOW = 2;
	localparam int FLAG_TX_HUNGRY = 3;
	localparam int NUM_FLAGS = 4;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		rd_idle = 2'b01,
		rd_answer = 2'b10
	} read_state_t;
endpackage

// ---- hw/link_status_monitor.sv ----
// link receive and transmit status monitor with an axi4-lite register slave
`timescale 1ns/1ps
module link_status_monitor
	import link_status_pkg::*;
#(
	parameter logic [28:0] LOCK_TICK = LOCK_TICK_CYCLES
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [NUM_LANES-1:0] lane_header_valid,
	input wire logic [NUM_LANES-1:0] lane_header_legal,
	input wire logic [NUM_LANES-1:0] lane_meta_valid,
	input wire logic [NUM_LANES-1:0] lane_meta_good,
	input wire logic lane_align_done,
	input wire logic crc24_error,
	input wire logic [NUM_LANES-1:0] lane_crc32_error,
	input wire logic rx_word_arrive,
	input wire logic rx_mac_ready,
	input wire logic [7:0] tx_fifo_level,
	input wire logic tx_fifo_write,
	input wire logic tx_fifo_full,
	input wire logic tx_fifo_read,
	input wire logic tx_fifo_empty,
	output logic [NUM_LANES-1:0] lane_word_lock,
	output logic [NUM_LANES-1:0] lane_sync_lock,
	output logic all_word_locked,
	output logic all_sync_locked,
	output logic fully_locked,
	output logic [15:0] locked_time,
	output logic [15:0] crc24_error_count,
	output logic [8*NUM_LANES-1:0] lane_crc_error_counters,
	output logic rx_overflow,
	output logic tx_hungry,
	output logic tx_idle_insert,
	output logic tx_overflow,
	output logic tx_underflow,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
		reg_hit = (addr[7:2] == offset[7:2]);
	endfunction

	function automatic logic reg_mapped(input logic [7:0] addr);
		reg_mapped = reg_hit(addr, REG_CTRL) || reg_hit(addr, REG_HUNGRY_THRESH)
			|| reg_hit(addr, REG_STATUS) || reg_hit(addr, REG_FLAGS)
			|| reg_hit(addr, REG_LOCKED_TIME) || reg_hit(addr, REG_CRC24_COUNT)
			|| reg_hit(addr, REG_WORD_LOCK) || reg_hit(addr, REG_SYNC_LOCK)
			|| reg_hit(addr, REG_CRC32_LO) || reg_hit(addr, REG_CRC32_HI);
	endfunction

	logic underflow_protect;
	logic [7:0] hungry_thresh;
	logic clear_counters;
	logic [NUM_FLAGS-1:0] sticky_flags;
	logic [NUM_FLAGS-1:0] flag_clear;
	logic [NUM_FLAGS-1:0] flag_events;

	// write channel holding registers
	logic aw_held;
	logic [7:0] aw_addr_q;
	logic w_held;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write;
	read_state_t read_state;
	logic [31:0] next_rdata;

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			aw_held <= 1'b0;
			aw_addr_q <= 8'h00;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		else if (do_write)
		begin
			aw_held <= 1'b0;
			s_axi_awready <= 1'b1;
		end
		else if (!aw_held)
		begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			w_held <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		else if (do_write)
		begin
			w_held <= 1'b0;
			s_axi_wready <= 1'b1;
		end
		else if (!w_held)
		begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= reg_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control registers; only byte lane 0 carries fields
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			underflow_protect <= CTRL_PROTECT_RESET;
			hungry_thresh <= HUNGRY_THRESH_RESET;
			clear_counters <= 1'b0;
			flag_clear <= '0;
		end
		else
		begin
			clear_counters <= 1'b0;
			flag_clear <= '0;
			if (do_write && w_strb_q[0])
			begin
				if (reg_hit(aw_addr_q, REG_CTRL))
				begin
					underflow_protect <= w_data_q[CTRL_PROTECT_BIT];
					clear_counters <= w_data_q[CTRL_CLEAR_BIT];
				end
				if (reg_hit(aw_addr_q, REG_HUNGRY_THRESH))
				begin
					hungry_thresh <= w_data_q[7:0];
				end
				if (reg_hit(aw_addr_q, REG_FLAGS))
				begin
					flag_clear <= w_data_q[NUM_FLAGS-1:0];
				end
			end
		end
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (1'b1)
			reg_hit(s_axi_araddr, REG_CTRL):
			begin
				next_rdata[CTRL_PROTECT_BIT] = underflow_protect;
			end
			reg_hit(s_axi_araddr, REG_HUNGRY_THRESH):
			begin
				next_rdata[7:0] = hungry_thresh;
			end
			reg_hit(s_axi_araddr, REG_STATUS):
			begin
				next_rdata[STATUS_ALL_WORD_BIT] = all_word_locked;
				next_rdata[STATUS_ALL_SYNC_BIT] = all_sync_locked;
				next_rdata[STATUS_FULL_BIT] = fully_locked;
				next_rdata[STATUS_ALIGN_BIT] = lane_align_done;
			end
			reg_hit(s_axi_araddr, REG_FLAGS):
			begin
				next_rdata[NUM_FLAGS-1:0] = sticky_flags;
			end
			reg_hit(s_axi_araddr, REG_LOCKED_TIME):
			begin
				next_rdata[15:0] = locked_time;
			end
			reg_hit(s_axi_araddr, REG_CRC24_COUNT):
			begin
				next_rdata[15:0] = crc24_error_count;
			end
			reg_hit(s_axi_araddr, REG_WORD_LOCK):
			begin
				next_rdata[NUM_LANES-1:0] = lane_word_lock;
			end
			reg_hit(s_axi_araddr, REG_SYNC_LOCK):
			begin
				next_rdata[NUM_LANES-1:0] = lane_sync_lock;
			end
			reg_hit(s_axi_araddr, REG_CRC32_LO):
			begin
				next_rdata = lane_crc_error_counters[31:0];
			end
			reg_hit(s_axi_araddr, REG_CRC32_HI):
			begin
				next_rdata = lane_crc_error_counters[63:32];
			end
			default:
			begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			read_state <= rd_idle;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			case (read_state)
				rd_idle:
				begin
					s_axi_arready <= 1'b1;
					if (s_axi_arvalid && s_axi_arready)
					begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata <= next_rdata;
						s_axi_rresp <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
						read_state <= rd_answer;
					end
				end
				rd_answer:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						s_axi_arready <= 1'b1;
						read_state <= rd_idle;
					end
				end
				default:
				begin
					read_state <= rd_idle;
					s_axi_arready <= 1'b0;
					s_axi_rvalid <= 1'b0;
				end
			endcase
		end
	end

	// per-lane lock tracking and crc-32 counters
	genvar lane;
	generate
		for (lane = 0; lane < NUM_LANES; lane++)
		begin : g_lane
			logic word_lock_q;
			logic sync_lock_q;
			logic [6:0] good_run;
			logic [5:0] window_pos;
			logic [4:0] bad_in_window;
			logic [2:0] sync_run;
			logic [7:0] crc32_count;

			assign lane_word_lock[lane] = word_lock_q;
			assign lane_sync_lock[lane] = sync_lock_q;
			assign lane_crc_error_counters[8*lane+7:8*lane] = crc32_count;

			always_ff @(posedge core_clk)
			begin
				if (rst)
				begin
					word_lock_q <= 1'b0;
					good_run <= 7'h00;
					window_pos <= 6'h00;
					bad_in_window <= 5'h00;
				end
				else if (lane_header_valid[lane] && !word_lock_q)
				begin
					if (!lane_header_legal[lane])
					begin
						good_run <= 7'h00;
					end
					else if (good_run == WORD_LOCK_GOOD - 7'h01)
					begin
						word_lock_q <= 1'b1;
						good_run <= 7'h00;
						window_pos <= 6'h00;
						bad_in_window <= 5'h00;
					end
					else
					begin
						good_run <= good_run + 7'h01;
					end
				end
				else if (lane_header_valid[lane])
				begin
					window_pos <= window_pos + 6'h01;
					if (!lane_header_legal[lane] && bad_in_window == WORD_LOSS_BAD - 5'h01)
					begin
						word_lock_q <= 1'b0;
						bad_in_window <= 5'h00;
					end
					else if (window_pos == WORD_WINDOW_LAST)
					begin
						bad_in_window <= 5'h00;
					end
					else if (!lane_header_legal[lane])
					begin
						bad_in_window <= bad_in_window + 5'h01;
					end
				end
			end

			// seed recovery is folded into meta_good by the descrambler
			always_ff @(posedge core_clk)
			begin
				if (rst || !word_lock_q)
				begin
					sync_lock_q <= 1'b0;
					sync_run <= 3'h0;
				end
				else if (lane_meta_valid[lane])
				begin
					if (lane_meta_good[lane] == sync_lock_q)
					begin
						sync_run <= 3'h0;
					end
					else if (!sync_lock_q && sync_run == SYNC_LOCK_GOOD - 3'h1)
					begin
						sync_lock_q <= 1'b1;
						sync_run <= 3'h0;
					end
					else if (sync_lock_q && sync_run == SYNC_LOSS_BAD - 3'h1)
					begin
						sync_lock_q <= 1'b0;
						sync_run <= 3'h0;
					end
					else
					begin
						sync_run <= sync_run + 3'h1;
					end
				end
			end

			always_ff @(posedge core_clk)
			begin
				if (rst || clear_counters)
				begin
					crc32_count <= 8'h00;
				end
				else if (lane_crc32_error[lane] && crc32_count != COUNT8_FULL)
				begin
					crc32_count <= crc32_count + 8'h01;
				end
			end
		end
	endgenerate

	// aggregates lag the lane bits by one cycle, full lock by two
	logic next_fully_locked;
	assign next_fully_locked = all_word_locked && all_sync_locked && lane_align_done;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			all_word_locked <= 1'b0;
			all_sync_locked <= 1'b0;
			fully_locked <= 1'b0;
		end
		else
		begin
			all_word_locked <= &lane_word_lock;
			all_sync_locked <= &lane_sync_lock;
			fully_locked <= next_fully_locked;
		end
	end

	logic [28:0] tick_count;

	// value is kept after lock loss so software can read the last span
	always_ff @(posedge core_clk)
	begin
		if (rst || (next_fully_locked && !fully_locked))
		begin
			tick_count <= 29'h0000_0000;
			locked_time <= 16'h0000;
		end
		else if (fully_locked)
		begin
			if (tick_count == LOCK_TICK - 29'h0000_0001)
			begin
				tick_count <= 29'h0000_0000;
				if (locked_time != COUNT16_FULL)
				begin
					locked_time <= locked_time + 16'h0001;
				end
			end
			else
			begin
				tick_count <= tick_count + 29'h0000_0001;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || clear_counters)
		begin
			crc24_error_count <= 16'h0000;
		end
		else if (crc24_error && crc24_error_count != COUNT16_FULL)
		begin
			crc24_error_count <= crc24_error_count + 16'h0001;
		end
	end

	// event flags; one cycle after their cause, all on core_clk
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rx_overflow <= 1'b0;
			tx_hungry <= 1'b0;
			tx_idle_insert <= 1'b0;
			tx_overflow <= 1'b0;
			tx_underflow <= 1'b0;
		end
		else
		begin
			rx_overflow <= rx_word_arrive && !rx_mac_ready;
			tx_hungry <= tx_fifo_level < hungry_thresh;
			tx_idle_insert <= underflow_protect && (tx_fifo_level < hungry_thresh);
			tx_overflow <= tx_fifo_write && tx_fifo_full;
			tx_underflow <= tx_fifo_read && tx_fifo_empty && !underflow_protect;
		end
	end

	assign flag_events[FLAG_RX_OVERFLOW] = rx_overflow;
	assign flag_events[FLAG_TX_OVERFLOW] = tx_overflow;
	assign flag_events[FLAG_TX_UNDERFLOW] = tx_underflow;
	assign flag_events[FLAG_TX_HUNGRY] = tx_hungry;

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sticky_flags <= '0;
		end
		else
		begin
			sticky_flags <= (sticky_flags & ~flag_clear) | flag_events;
		end
	end

endmodule

// ---- dv/link_status_monitor_monitor.sv ----
// concurrent checks on the link status monitor ports
`timescale 1ns/1ps
module link_status_monitor_monitor
	import link_status_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [NUM_LANES-1:0] lane_header_valid,
	input wire logic [NUM_LANES-1:0] lane_header_legal,
	input wire logic [NUM_LANES-1:0] lane_word_lock,
	input wire logic [NUM_LANES-1:0] lane_sync_lock,
	input wire logic all_word_locked,
	input wire logic all_sync_locked,
	input wire logic fully_locked,
	input wire logic lane_align_done,
	input wire logic [NUM_LANES-1:0] lane_crc32_error,
	input wire logic [8*NUM_LANES-1:0] lane_crc_error_counters,
	input wire logic rx_word_arrive,
	input wire logic rx_mac_ready,
	input wire logic rx_overflow,
	input wire logic tx_fifo_write,
	input wire logic tx_fifo_full,
	input wire logic tx_overflow,
	input wire logic tx_hungry,
	input wire logic tx_idle_insert
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_all_up;
		all_word_locked && all_sync_locked && lane_align_done;
	endsequence
	a_word_cause: assert property (
		$rose(lane_word_lock[0]) |-> $past(lane_header_valid[0] && lane_header_legal[0]))
		else $error("word lock rose without a legal header");
	a_sync_needs_word: assert property (
		(lane_sync_lock & ~$past(lane_word_lock)) == '0)
		else $error("sync lock without word lock");
	a_all_word: assert property (
		all_word_locked == &$past(lane_word_lock))
		else $error("aggregate word lock wrong");
	a_all_sync: assert property (
		$rose(all_sync_locked) |-> &$past(lane_sync_lock))
		else $error("aggregate sync lock rose early");
	a_full_up: assert property (s_all_up |=> fully_locked)
		else $error("full lock missing");
	a_full_down: assert property (
		fully_locked |-> $past(all_word_locked && all_sync_locked && lane_align_done))
		else $error("full lock held without cause");
	a_lane_count: assert property (
		lane_crc32_error[1] && lane_crc_error_counters[15:8] != COUNT8_FULL
		|=> lane_crc_error_counters[15:8] == $past(lane_crc_error_counters[15:8]) + 8'h01)
		else $error("lane one counter did not step");
	a_lane_sat: assert property (
		lane_crc_error_counters[7:0] == COUNT8_FULL |=> lane_crc_error_counters[7:0] == COUNT8_FULL)
		else $error("lane counter wrapped");
	a_rx_ovf: assert property (
		rx_overflow == $past(rx_word_arrive && !rx_mac_ready))
		else $error("receive overflow wrong");
	a_tx_ovf: assert property (tx_fifo_write && tx_fifo_full |=> tx_overflow)
		else $error("transmit overflow missed");
	a_idle_hungry: assert property (tx_idle_insert |-> tx_hungry)
		else $error("idle insert without hungry");
endmodule
bind link_status_monitor link_status_monitor_monitor link_status_monitor_monitor_inst (.*);

// ---- dv/app_health_watch.sv ----
// application side model watching the link health outputs
`timescale 1ns/1ps
module app_health_watch
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic rx_overflow,
	input wire logic tx_hungry,
	output logic backpressure,
	output logic [15:0] hungry_cycles
);
	// optional back-pressure, latched so a single pulse is not missed
	always_ff @(posedge core_clk)
	begin
		if (rst)
			backpressure <= 1'b0;
		else if (rx_overflow)
			backpressure <= 1'b1;
	end
	// hungry is only a warning: counted, never acted upon
	always_ff @(posedge core_clk)
	begin
		if (rst)
			hungry_cycles <= 16'h0000;
		else if (tx_hungry)
			hungry_cycles <= hungry_cycles + 16'h0001;
	end
endmodule

// ---- dv/link_status_monitor_tb.sv ----
// self-checking bench for the link status monitor
`timescale 1ns/1ps
module link_status_monitor_tb
	import link_status_pkg::*;
;
	logic core_clk = 1'b0, rst = 1'b1, lane_align_done = 1'b0, crc24_error = 1'b0;
	logic [7:0] lane_header_valid = '0, lane_header_legal = '0, lane_meta_valid = '0;
	logic [7:0] lane_meta_good = '0, lane_crc32_error = '0, tx_fifo_level = 8'h20;
	logic rx_word_arrive = 1'b0, rx_mac_ready = 1'b0, tx_fifo_write = 1'b0, tx_fifo_full = 1'b0;
	logic tx_fifo_read = 1'b0, tx_fifo_empty = 1'b0;
	logic [7:0] lane_word_lock, lane_sync_lock, s_axi_awaddr = '0, s_axi_araddr = '0;
	logic all_word_locked, all_sync_locked, fully_locked, rx_overflow, tx_hungry;
	logic tx_idle_insert, tx_overflow, tx_underflow, backpressure;
	logic [15:0] locked_time, crc24_error_count, hungry_cycles;
	logic [63:0] lane_crc_error_counters;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int n_fail = 0, n_checks = 0, cycles = 0, n_ov = 0, n_txo = 0, n_txu = 0;
	logic [7:0] ra [6] = '{REG_CTRL, REG_HUNGRY_THRESH, REG_STATUS, REG_FLAGS, REG_CRC24_COUNT, 8'h40};
	logic [31:0] rv [6] = '{32'h0000_0001, 32'h0000_0004, '0, '0, '0, '0};

	link_status_monitor #(.LOCK_TICK(29'h0000_0008)) link_status_monitor_inst (.*);
	app_health_watch app_health_watch_inst (.core_clk, .rst, .rx_overflow, .tx_hungry,
		.backpressure, .hungry_cycles);

	always #4 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		cycles++;
		n_ov += (!rst && rx_overflow);
		n_txo += (!rst && tx_overflow);
		n_txu += (!rst && tx_underflow);
		if (cycles == 20000)
		begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// each channel drops its valid at the edge where its own ready is seen
		do
		begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		do @(posedge core_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	// m selects meta words, otherwise sync headers
	task automatic strobe(input bit m, input int n, input logic [7:0] on, input logic [7:0] ok);
		repeat (n)
		begin
			@(posedge core_clk);
			lane_meta_valid <= m ? on : 8'h00;
			lane_header_valid <= m ? 8'h00 : on;
			lane_meta_good <= ok;
			lane_header_legal <= ok;
		end
		@(posedge core_clk);
		lane_meta_valid <= '0;
		lane_header_valid <= '0;
		tick(3);
	endtask

	task automatic tx_evt(input logic [1:0] ev);
		@(posedge core_clk);
		{tx_fifo_write, tx_fifo_full} <= {2{ev[0]}};
		{tx_fifo_read, tx_fifo_empty} <= {2{ev[1]}};
		@(posedge core_clk);
		{tx_fifo_write, tx_fifo_full, tx_fifo_read, tx_fifo_empty} <= '0;
		tick(3);
	endtask

	initial
	begin
		logic [31:0] d, rn;
		logic [1:0] r;
		int x24, xov;
		int x32 [8];
		void'($urandom(32'h4408));
		x24 = 0;
		xov = 0;
		x32 = '{default: 0};
		tick(16);
		rst <= 1'b0;
		tick(2);
		for (int i = 0; i < 6; i++)
		begin
			rd(ra[i], d, r);
			chk("reset value", rv[i], d);
			chk("rresp", (i == 5) ? RESP_SLVERR : RESP_OKAY, r);
		end
		strobe(0, 63, 8'hFF, 8'hFF);
		chk("word lock early", 0, lane_word_lock);
		strobe(0, 1, 8'hFF, 8'hFF);
		chk("word lock", 8'hFF, lane_word_lock);
		chk("all word", 1, all_word_locked);
		strobe(1, 4, 8'hFF, 8'hFF);
		chk("sync lock", 8'hFF, lane_sync_lock);
		chk("all sync", 1, all_sync_locked);
		chk("full before align", 0, fully_locked);
		lane_align_done <= 1'b1;
		tick(3);
		chk("full", 1, fully_locked);
		tick(80);
		chk("locked time", 10, locked_time);
		rd(REG_STATUS, d, r);
		chk("status", 32'h0000_000F, d);
		lane_align_done <= 1'b0;
		tick(3);
		chk("full after align loss", 0, fully_locked);
		strobe(1, 4, 8'h08, 8'h00);
		chk("sync lane 3 lost", 8'hF7, lane_sync_lock);
		chk("all sync lost", 0, all_sync_locked);
		strobe(0, 15, 8'h04, 8'h00);
		chk("word lock at 15 bad", 8'hFF, lane_word_lock);
		strobe(0, 1, 8'h04, 8'h00);
		chk("word lane 2 lost", 8'hFB, lane_word_lock);
		chk("sync follows word", 8'hF3, lane_sync_lock);
		for (int i = 0; i < 200; i++)
		begin
			@(posedge core_clk);
			rn = $urandom;
			crc24_error <= rn[1:0] == 2'b00;
			lane_crc32_error <= rn[15:8];
			rx_word_arrive <= rn[16];
			rx_mac_ready <= rn[17];
			x24 += (rn[1:0] == 2'b00);
			xov += (rn[16] && !rn[17]);
			for (int l = 0; l < 8; l++)
				x32[l] += rn[8 + l];
		end
		@(posedge core_clk);
		{crc24_error, lane_crc32_error, rx_word_arrive} <= '0;
		tick(3);
		chk("crc24 count", x24, crc24_error_count);
		for (int l = 0; l < 8; l++)
			chk("lane crc count", x32[l], lane_crc_error_counters[8*l +: 8]);
		rd(REG_CRC32_LO, d, r);
		chk("crc lo", {x32[3][7:0], x32[2][7:0], x32[1][7:0], x32[0][7:0]}, d);
		chk("overflow pulses", xov, n_ov);
		chk("backpressure", 1, backpressure);
		lane_crc32_error <= 8'h01;
		tick(300);
		lane_crc32_error <= '0;
		tick(3);
		chk("lane 0 saturated", 8'hFF, lane_crc_error_counters[7:0]);
		tx_fifo_level <= 8'h04;
		tick(3);
		chk("not hungry at 4", 0, tx_hungry);
		chk("no hungry cycles", 0, hungry_cycles);
		tx_fifo_level <= 8'h03;
		tick(3);
		chk("hungry", 1, tx_hungry);
		chk("idle insert", 1, tx_idle_insert);
		chk("hungry cycles", 1, hungry_cycles != 16'h0000);
		tx_evt(2'b11);
		chk("tx overflow", 1, n_txo);
		chk("no underflow protected", 0, n_txu);
		wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		tick(3);
		chk("idle insert off", 0, tx_idle_insert);
		tx_evt(2'b10);
		chk("tx underflow", 1, n_txu);
		rd(REG_FLAGS, d, r);
		chk("sticky flags", 32'h0000_000F, d);
		wr(8'h40, 32'h0000_0000, RESP_SLVERR);
		final_report();
	end
endmodule
